// ---- hw/ups_defines.vh ----
`ifndef UPS_DEFINES_VH
`define UPS_DEFINES_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define UPS_PORT1_OFFSET 8'h64
`define UPS_PORT2_OFFSET 8'h68
`define UPS_PORT_STRIDE 8'h04
`define UPS_INT_STATUS_OFFSET 8'h70
`define UPS_INT_MASK_OFFSET 8'h74

// ****************************************
// port status and control field positions
// ****************************************
`define UPS_BIT_WAKE_OC 22
`define UPS_BIT_WAKE_DETACH 21
`define UPS_BIT_WAKE_ATTACH 20
`define UPS_TEST_HI 19
`define UPS_TEST_LO 16
`define UPS_BIT_OWNER 13
`define UPS_BIT_POWER 12
`define UPS_BIT_LINE_DP 11
`define UPS_BIT_LINE_DM 10
`define UPS_BIT_PORT_RESET 8
`define UPS_BIT_SUSPEND 7
`define UPS_BIT_FORCE_RESUME 6
`define UPS_BIT_OC_CHANGE 5
`define UPS_BIT_OC_ACTIVE 4
`define UPS_BIT_ENABLE_CHANGE 3
`define UPS_BIT_ENABLE 2
`define UPS_BIT_CONNECT_CHANGE 1
`define UPS_BIT_CONNECT 0

// ****************************************
// reset values
// ****************************************
`define UPS_RST_WAKE 1'b0
`define UPS_RST_TEST 4'h0
`define UPS_RST_OWNER 1'b1
`define UPS_RST_POWER 1'b0
`define UPS_RST_FLAG 1'b0
`define UPS_RST_INT_MASK 8'h00
`define UPS_RST_DATA 32'h0000_0000
`define UPS_RST_PIN_SYNC 9'h100

// ****************************************
// test control encodings
// ****************************************
`define UPS_TEST_NORMAL 4'h0
`define UPS_TEST_J_STATE 4'h1

// ****************************************
// interrupt status layout
// ****************************************
`define UPS_INT_WIDTH 8
`define UPS_INT_CONNECT_LO 0
`define UPS_INT_OC_LO 2
`define UPS_INT_WAKE_LO 4
`define UPS_INT_ENABLE_LO 6

`endif

// ---- hw/ups_port_regs.v ----
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "ups_defines.vh"

// What this block does
// - registers cleared only by power-on or controller reset
// - after reset: nothing connected, port disabled
// - port registers decoded at 64h plus four per port
// - bit 22 makes overcurrent a wake event
// - bit 21 makes detach a wake event
// - bit 20 makes attach a wake event
// - test field bits 19:16, zero normal, 0001b J
// - owner bit resets one, held one while routing flag low, cleared when it rises
// - overcurrent may remove power; unpowered reports no status bits
module ups_port_regs (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // wishbone slave
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [7:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatI,
    output reg [31:0] wbDatO,
    output reg wbAck,
    // routing flag from the configure register, same clock
    input wire routingFlag,
    // port reset in progress, from the port engine, same clock
    input wire [1:0] portResetActive,
    // port pins, asynchronous
    input wire powerSwitchPresent,
    input wire [1:0] connectPin,
    input wire [1:0] overcurrentPin,
    input wire [1:0] lineDp,
    input wire [1:0] lineDm,
    // port controls
    output reg [1:0] portPowerOn,
    output reg [1:0] portOwnership,
    output reg [1:0] portEnabled,
    output reg [1:0] portSuspend,
    output reg [1:0] portForceResume,
    output reg [7:0] testControlField,
    output reg [1:0] wakeEvent,
    // interrupt
    output reg irq
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [8:0] pinSync1;
    reg [8:0] pinSync2;
    wire [8:0] pinRaw;
    wire ppcOn;
    wire [1:0] connSync;
    wire [1:0] ocSync;
    wire [1:0] dpSync;
    wire [1:0] dmSync;

    assign pinRaw = {powerSwitchPresent, connectPin, overcurrentPin, lineDp, lineDm};

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // strap reads as switched until synced, so power stays off
            pinSync1 <= `UPS_RST_PIN_SYNC;
            pinSync2 <= `UPS_RST_PIN_SYNC;
        end else begin
            pinSync1 <= pinRaw;
            pinSync2 <= pinSync1;
        end
    end

    assign ppcOn = pinSync2[8];
    assign connSync = pinSync2[7:6];
    assign ocSync = pinSync2[5:4];
    assign dpSync = pinSync2[3:2];
    assign dmSync = pinSync2[1:0];

    // ****************************************
    // per-port storage
    // ****************************************
    reg [1:0] wakeOcEn;
    reg [1:0] wakeDetachEn;
    reg [1:0] wakeAttachEn;
    reg [1:0] connectState;
    reg [1:0] connectChange;
    reg [1:0] enableChange;
    reg [1:0] ocState;
    reg [1:0] ocChange;
    reg routingFlagPrev;
    reg [`UPS_INT_WIDTH-1:0] intStatus;
    reg [`UPS_INT_WIDTH-1:0] intMask;

    // ****************************************
    // bus decode
    // ****************************************
    wire wbReq;
    wire wbWrite;
    wire wbRead;
    wire [1:0] portHit;
    wire statusHit;
    wire maskHit;
    wire routingRise;
    wire [1:0] livePower;
    wire [1:0] liveConnect;
    wire [1:0] attachEdge;
    wire [1:0] detachEdge;
    wire [1:0] ocRise;
    wire [1:0] ocEdge;
    wire [1:0] wakeNow;
    reg [63:0] portView;
    reg [63:0] portWrite;
    reg [31:0] next_wbDatO;
    reg [`UPS_INT_WIDTH-1:0] next_intStatus;
    integer i;
    integer p;

    assign wbReq = wbCyc & wbStb & ~wbAck;
    assign wbWrite = wbReq & wbWe;
    assign wbRead = wbReq & ~wbWe;
    // word compare, byte lanes ignored
    assign portHit[0] = ({wbAdr[7:2], 2'b00} == `UPS_PORT1_OFFSET);
    assign portHit[1] = ({wbAdr[7:2], 2'b00} == `UPS_PORT2_OFFSET);
    assign statusHit = ({wbAdr[7:2], 2'b00} == `UPS_INT_STATUS_OFFSET);
    assign maskHit = ({wbAdr[7:2], 2'b00} == `UPS_INT_MASK_OFFSET);
    assign routingRise = routingFlag & ~routingFlagPrev;

    // power off silences the port
    assign livePower = ppcOn ? portPowerOn : 2'b11;
    assign liveConnect = connSync & livePower;
    assign attachEdge = liveConnect & ~connectState;
    assign detachEdge = ~liveConnect & connectState;
    assign ocEdge = (ocSync & livePower) ^ ocState;
    assign ocRise = ocSync & livePower & ~ocState;
    assign wakeNow = (wakeOcEn & ocRise)
        | (wakeDetachEn & detachEdge)
        | (wakeAttachEn & attachEdge);

    // ****************************************
    // byte-lane merge
    // ****************************************
    function [31:0] mergeLanes;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0] lanes;
        integer b;
        begin
            mergeLanes = oldVal;
            for (b = 0; b < 4; b = b + 1) begin
                if (lanes[b]) begin
                    mergeLanes[b*8 +: 8] = newVal[b*8 +: 8];
                end
            end
        end
    endfunction

    // ****************************************
    // read-back view of each port
    // ****************************************
    always @* begin
        portView = 64'h0000_0000_0000_0000;
        for (p = 0; p < 2; p = p + 1) begin
            portView[p*32 + `UPS_BIT_WAKE_OC] = wakeOcEn[p];
            portView[p*32 + `UPS_BIT_WAKE_DETACH] = wakeDetachEn[p];
            portView[p*32 + `UPS_BIT_WAKE_ATTACH] = wakeAttachEn[p];
            portView[p*32 + `UPS_TEST_LO +: 4] = testControlField[p*4 +: 4];
            portView[p*32 + `UPS_BIT_OWNER] = portOwnership[p];
            portView[p*32 + `UPS_BIT_POWER] = portPowerOn[p];
            // unpowered port reports no status
            if (livePower[p]) begin
                portView[p*32 + `UPS_BIT_LINE_DP] = dpSync[p];
                portView[p*32 + `UPS_BIT_LINE_DM] = dmSync[p];
                portView[p*32 + `UPS_BIT_PORT_RESET] = portResetActive[p];
                portView[p*32 + `UPS_BIT_SUSPEND] = portSuspend[p];
                portView[p*32 + `UPS_BIT_FORCE_RESUME] = portForceResume[p];
                portView[p*32 + `UPS_BIT_OC_CHANGE] = ocChange[p];
                portView[p*32 + `UPS_BIT_OC_ACTIVE] = ocState[p];
                portView[p*32 + `UPS_BIT_ENABLE_CHANGE] = enableChange[p];
                portView[p*32 + `UPS_BIT_ENABLE] = portEnabled[p];
                portView[p*32 + `UPS_BIT_CONNECT_CHANGE] = connectChange[p];
                portView[p*32 + `UPS_BIT_CONNECT] = connectState[p];
            end
        end
    end

    always @* begin
        portWrite[31:0] = mergeLanes(portView[31:0], wbDatI, wbSel);
        portWrite[63:32] = mergeLanes(portView[63:32], wbDatI, wbSel);
    end

    // ****************************************
    // read data mux and interrupt status
    // ****************************************
    always @* begin
        next_wbDatO = `UPS_RST_DATA;
        if (portHit[0]) begin
            next_wbDatO = portView[31:0];
        end else if (portHit[1]) begin
            next_wbDatO = portView[63:32];
        end else if (statusHit) begin
            next_wbDatO = {24'h00_0000, intStatus};
        end else if (maskHit) begin
            next_wbDatO = {24'h00_0000, intMask};
        end
    end

    always @* begin
        next_intStatus = intStatus;
        if (wbRead & statusHit) begin
            next_intStatus = {`UPS_INT_WIDTH{1'b0}};
        end
        // new events win over the read clear
        next_intStatus[`UPS_INT_CONNECT_LO +: 2] = next_intStatus[`UPS_INT_CONNECT_LO +: 2]
            | attachEdge | detachEdge;
        next_intStatus[`UPS_INT_OC_LO +: 2] = next_intStatus[`UPS_INT_OC_LO +: 2] | ocEdge;
        next_intStatus[`UPS_INT_WAKE_LO +: 2] = next_intStatus[`UPS_INT_WAKE_LO +: 2] | wakeNow;
        next_intStatus[`UPS_INT_ENABLE_LO +: 2] = next_intStatus[`UPS_INT_ENABLE_LO +: 2]
            | (detachEdge & portEnabled);
    end

    // ****************************************
    // wishbone handshake
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wbAck <= 1'b0;
            wbDatO <= `UPS_RST_DATA;
        end else begin
            wbAck <= wbReq;
            if (wbRead) begin
                wbDatO <= next_wbDatO;
            end
        end
    end

    // ****************************************
    // interrupt status, mask and output
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            intStatus <= {`UPS_INT_WIDTH{1'b0}};
            intMask <= `UPS_RST_INT_MASK;
            irq <= 1'b0;
        end else begin
            intStatus <= next_intStatus;
            if (wbWrite & maskHit & wbSel[0]) begin
                intMask <= wbDatI[7:0];
            end
            irq <= |(next_intStatus & intMask);
        end
    end

    // ****************************************
    // port registers
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // cleared only by power-on or controller reset
            routingFlagPrev <= `UPS_RST_FLAG;
            wakeOcEn <= {2{`UPS_RST_WAKE}};
            wakeDetachEn <= {2{`UPS_RST_WAKE}};
            wakeAttachEn <= {2{`UPS_RST_WAKE}};
            testControlField <= {2{`UPS_RST_TEST}};
            portOwnership <= {2{`UPS_RST_OWNER}};
            portPowerOn <= {2{`UPS_RST_POWER}};
            connectState <= 2'b00;
            portEnabled <= 2'b00;
            connectChange <= 2'b00;
            enableChange <= 2'b00;
            ocState <= 2'b00;
            ocChange <= 2'b00;
            portSuspend <= 2'b00;
            portForceResume <= 2'b00;
            wakeEvent <= 2'b00;
        end else begin
            routingFlagPrev <= routingFlag;
            wakeEvent <= wakeNow;
            for (i = 0; i < 2; i = i + 1) begin
                // software side first, hardware events override below
                if (wbWrite & portHit[i]) begin
                    wakeOcEn[i] <= portWrite[i*32 + `UPS_BIT_WAKE_OC];
                    wakeDetachEn[i] <= portWrite[i*32 + `UPS_BIT_WAKE_DETACH];
                    wakeAttachEn[i] <= portWrite[i*32 + `UPS_BIT_WAKE_ATTACH];
                    testControlField[i*4 +: 4] <= portWrite[i*32 + `UPS_TEST_LO +: 4];
                    portOwnership[i] <= portWrite[i*32 + `UPS_BIT_OWNER];
                    if (ppcOn) begin
                        portPowerOn[i] <= portWrite[i*32 + `UPS_BIT_POWER];
                    end
                    if (livePower[i]) begin
                        portSuspend[i] <= portWrite[i*32 + `UPS_BIT_SUSPEND];
                        portForceResume[i] <= portWrite[i*32 + `UPS_BIT_FORCE_RESUME];
                        portEnabled[i] <= portWrite[i*32 + `UPS_BIT_ENABLE] & connectState[i];
                    end
                    // write one clears enable and connect change flags
                    if (wbDatI[`UPS_BIT_ENABLE_CHANGE] & wbSel[0]) begin
                        enableChange[i] <= 1'b0;
                    end
                    if (wbDatI[`UPS_BIT_CONNECT_CHANGE] & wbSel[0]) begin
                        connectChange[i] <= 1'b0;
                    end
                end
                if (wbRead & portHit[i]) begin
                    ocChange[i] <= 1'b0;
                end
                // hardware status and events; connect and overcurrent state are never written by software
                connectState[i] <= liveConnect[i];
                ocState[i] <= ocSync[i] & livePower[i];
                if (attachEdge[i] | detachEdge[i]) begin
                    connectChange[i] <= 1'b1;
                end
                if (ocEdge[i]) begin
                    ocChange[i] <= 1'b1;
                end
                if (detachEdge[i] & portEnabled[i]) begin
                    portEnabled[i] <= 1'b0;
                    enableChange[i] <= 1'b1;
                end
                if (~livePower[i]) begin
                    portEnabled[i] <= 1'b0;
                    portSuspend[i] <= 1'b0;
                    portForceResume[i] <= 1'b0;
                end
                if (~ppcOn) begin
                    portPowerOn[i] <= 1'b1;
                end else if (ocRise[i]) begin
                    portPowerOn[i] <= 1'b0;
                end
                if (~routingFlag) begin
                    portOwnership[i] <= 1'b1;
                end else if (routingRise) begin
                    portOwnership[i] <= 1'b0;
                end
            end
        end
    end

endmodule

// ---- sim/ups_usb_device.sv ----
`timescale 1ns/1ps
// ****************************************
// attached device model, both ports
// ****************************************
module ups_usb_device (
    // clock
    input wire core_clk,
    // bench commands, bit0 = port1
    input wire [1:0] attach,
    input wire [1:0] overload,
    // port pins
    output reg [1:0] connectPin,
    output reg [1:0] overcurrentPin,
    output reg [1:0] lineDp,
    output reg [1:0] lineDm
);
    initial begin
        connectPin = 2'b00;
        overcurrentPin = 2'b00;
        lineDp = 2'b00;
        lineDm = 2'b00;
    end
    // full-speed idle is dp high, dm low; a detached pair is pulled low
    always @(posedge core_clk) begin
        connectPin <= attach;
        overcurrentPin <= overload;
        lineDp <= attach;
        lineDm <= 2'b00;
    end
endmodule

// ---- sim/ups_port_regs_props.sv ----
`timescale 1ns/1ps
// ****************************************
// port register checker
// ****************************************
module ups_port_regs_props (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // bus
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [31:0] wbDatO,
    input wire wbAck,
    // port side
    input wire routingFlag,
    input wire powerSwitchPresent,
    input wire [1:0] overcurrentPin,
    input wire [1:0] portPowerOn,
    input wire [1:0] portOwnership,
    input wire [7:0] testControlField,
    input wire [1:0] wakeEvent,
    input wire irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_taken;
        wbCyc && wbStb && !wbAck;
    endsequence
    sequence s_ackOnce;
        wbAck ##1 !wbAck;
    endsequence
    sequence s_ocSeen;
        $rose(overcurrentPin[0]) && powerSwitchPresent;
    endsequence
    sequence s_quiet;
        !wbAck && !irq && wakeEvent == 2'b00 && testControlField == 8'h00 && portOwnership == 2'b11;
    endsequence
    chk_ack_answer: assert property (s_taken |=> s_ackOnce)
        else $error("ack missing or too long");
    chk_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
        else $error("ack without request");
    chk_dat_hold: assert property ($changed(wbDatO) |-> wbAck && !$past(wbWe))
        else $error("read data changed outside a read");
    chk_test_write: assert property ($changed(testControlField) |-> wbAck && $past(wbWe))
        else $error("test field changed without write");
    chk_owner_forced: assert property (!routingFlag |=> portOwnership == 2'b11)
        else $error("owner not held while flag low");
    chk_owner_clear: assert property ($rose(routingFlag) |=> portOwnership == 2'b00)
        else $error("owner not cleared on flag rise");
    chk_wake_pulse: assert property (|wakeEvent |=> !(|(wakeEvent & $past(wakeEvent))))
        else $error("wake event longer than one cycle");
    chk_oc_power: assert property (s_ocSeen |-> ##[1:6] !portPowerOn[0])
        else $error("overcurrent left power on");
    chk_reset_quiet: assert property ($fell(rst) |-> s_quiet)
        else $error("outputs not at reset values");
endmodule
bind ups_port_regs ups_port_regs_props chk (.core_clk(core_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbDatO(wbDatO), .wbAck(wbAck), .routingFlag(routingFlag),
    .powerSwitchPresent(powerSwitchPresent), .overcurrentPin(overcurrentPin), .portPowerOn(portPowerOn),
    .portOwnership(portOwnership), .testControlField(testControlField), .wakeEvent(wakeEvent), .irq(irq));

// ---- sim/test_usb_port_status_control.sv ----
`timescale 1ns/1ps
// ****************************************
// port register bench
// ****************************************
module test_usb_port_status_control;
    typedef struct packed {logic [7:0] a; logic [3:0] s; logic [31:0] w; logic [31:0] e;} ups_row_t;
    logic core_clk, rst, wbCyc, wbStb, wbWe, wbAck, routingFlag, powerSwitchPresent, irq;
    logic [7:0] wbAdr, testControlField;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO, q;
    logic [1:0] portResetActive, attachCmd, ocCmd, connectPin, overcurrentPin, lineDp, lineDm;
    logic [1:0] portPowerOn, portOwnership, portEnabled, portSuspend, portForceResume, wakeEvent;
    integer err_count, checks_done, i, n;
    ups_row_t rows [0:7];
    localparam int settleWait = 20; // shortened power settle wait
    ups_port_regs dut (.core_clk(core_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .routingFlag(routingFlag), .portResetActive(portResetActive), .powerSwitchPresent(powerSwitchPresent),
        .connectPin(connectPin), .overcurrentPin(overcurrentPin), .lineDp(lineDp), .lineDm(lineDm),
        .portPowerOn(portPowerOn), .portOwnership(portOwnership), .portEnabled(portEnabled),
        .portSuspend(portSuspend), .portForceResume(portForceResume), .testControlField(testControlField),
        .wakeEvent(wakeEvent), .irq(irq));
    ups_usb_device dev (.core_clk(core_clk), .attach(attachCmd), .overload(ocCmd), .connectPin(connectPin),
        .overcurrentPin(overcurrentPin), .lineDp(lineDp), .lineDm(lineDm));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #500000;
        err_count = err_count + 1;
        conclude;
    end
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task ticks(input integer k);
        repeat (k) @(posedge core_clk);
    endtask
    task xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] w);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= s;
        wbDatI <= w;
        n = 0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (wbAck !== 1'b1);
        check("ack cycles", 32'd2, n);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask
    task rd(input string name, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 4'hF, 32'h0000_0000);
        check(name, e, q);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {rst, wbCyc, wbStb, wbWe, routingFlag, wbAdr, wbSel, wbDatI} = {1'b1, 48'h0};
        {portResetActive, attachCmd, ocCmd, powerSwitchPresent} = 7'h01;
        err_count = 0;
        checks_done = 0;
        rows[0] = '{8'h64, 4'hF, 32'h0040_1000, 32'h0040_3000};
        rows[1] = '{8'h64, 4'hF, 32'h0020_1000, 32'h0020_3000};
        rows[2] = '{8'h64, 4'hF, 32'h000F_1131, 32'h000F_3000};
        rows[3] = '{8'h64, 4'h4, 32'h0001_0000, 32'h0001_3000};
        rows[4] = '{8'h68, 4'hF, 32'h0001_1000, 32'h0001_3000};
        rows[5] = '{8'h74, 4'hF, 32'h0000_0011, 32'h0000_0011};
        rows[6] = '{8'h60, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[7] = '{8'h64, 4'hF, 32'h0010_1000, 32'h0010_3000};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd("port1 reset", 8'h64, 32'h0000_2000);
        rd("port2 reset", 8'h68, 32'h0000_2000);
        check("owner", 32'h3, {30'h0, portOwnership});
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            xfer(1'b1, rows[i].a, rows[i].s, rows[i].w);
            if (i == 0) ticks(settleWait);
            rd("row", rows[i].a, rows[i].e);
        end
        check("test field", 32'h10, {24'h0, testControlField});
        $display("test table done");
        routingFlag <= 1'b1;
        ticks(3);
        check("owner cleared", 32'h0, {30'h0, portOwnership});
        rd("port1 routed", 8'h64, 32'h0010_1000);
        routingFlag <= 1'b0;
        ticks(2);
        check("owner forced", 32'h3, {30'h0, portOwnership});
        $display("test routing done");
        attachCmd <= 2'b01;
        n = 0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (wakeEvent[0] !== 1'b1 && n < 20);
        check("wake attach", 32'h1, {31'h0, wakeEvent[0]});
        ticks(3);
        check("irq set", 32'h1, {31'h0, irq});
        rd("port1 attached", 8'h64, 32'h0010_3803);
        rd("status", 8'h70, 32'h0000_0011);
        ticks(3);
        check("irq clear", 32'h0, {31'h0, irq});
        rd("status empty", 8'h70, 32'h0000_0000);
        xfer(1'b1, 8'h64, 4'hF, 32'h0010_10C4);
        check("port1 controls", 32'h7, {29'h0, portEnabled[0], portSuspend[0], portForceResume[0]});
        rd("port1 enabled", 8'h64, 32'h0010_38C7);
        $display("test attach done");
        ocCmd <= 2'b01;
        ticks(8);
        check("power off", 32'h2, {30'h0, portPowerOn});
        check("port1 silenced", 32'h0, {29'h0, portEnabled[0], portSuspend[0], portForceResume[0]});
        rd("port1 unpowered", 8'h64, 32'h0010_2000);
        rd("status oc", 8'h70, 32'h0000_0045);
        ocCmd <= 2'b00;
        portResetActive <= 2'b10;
        ticks(1);
        rd("port2 in reset", 8'h68, 32'h0001_3100);
        portResetActive <= 2'b00;
        $display("test overcurrent done");
        rst <= 1'b1;
        ticks(2);
        rst <= 1'b0;
        rd("port1 second reset", 8'h64, 32'h0000_2000);
        check("test field reset", 32'h0, {24'h0, testControlField});
        powerSwitchPresent <= 1'b0;
        ticks(4);
        check("strap power", 32'h3, {30'h0, portPowerOn});
        rd("port1 unswitched", 8'h64, 32'h0000_3803);
        $display("test second reset done");
        conclude;
    end
endmodule
